/* File: src/vtc_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Decoder tone detect reports frequency in info
// - Decoder tone generate needs detect enabled too
// - Decoder order bit matters only with both detects
// - Encoder keypad detect posts key code
// - Encoder tone detect posts frequency, else voice
// - Encoder order bit matters only with both detects
// - Codec command write pushes word, bumps count; dropped when queue full
// - Push completion sets ready and interrupt
// - Queue empty at reset, kept until clear
// - Count readable; acknowledge bit 0 marks completion
// - Serial port start replays every queued word
// - Watermark write completion sets ready bit
// - Output buffer holds up to 800 samples
// - Below low mark sets data-wanted once
// - Watermark is 11 bits, 11-14 reserved
// - Bit 15 picks high mark and disarms
// - Control write completes with ready bit
// - Interrupt low when enabled status bit sets
module vtc_regs
    import vtc_pkg::*;
#(
    parameter int SETTLE_CYC = CTRL_SETTLE_CYC
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESET_N,
    input  wire logic        BUS_WR,
    input  wire logic        BUS_RD,
    input  wire logic [7:0]  BUS_ADDR,
    input  wire logic [15:0] BUS_WDATA,
    output logic      [15:0] BUS_RDATA,
    input  wire logic        DEC_FRAME_VALID,
    input  wire logic        DEC_FRAME_IS_TONE,
    input  wire logic        DEC_FRAME_IS_KEYPAD,
    input  wire logic [11:0] DEC_FRAME_DATA,
    input  wire logic        ENC_AUDIO_VALID,
    input  wire logic        ENC_AUDIO_IS_TONE,
    input  wire logic        ENC_AUDIO_IS_KEYPAD,
    input  wire logic [11:0] ENC_AUDIO_DATA,
    input  wire logic [10:0] SAMPLE_COUNT,
    input  wire logic        PORT_START,
    input  wire logic        PORT_TX_READY,
    output logic             PORT_TX_VALID,
    output logic      [15:0] PORT_TX_DATA,
    output logic             DEC_TONE_SYNTH,
    output logic             FAST_SPEED,
    output logic             INTERRUPT_N
);
    // Refused at elaboration: a zero settle count never raises ready
    if (SETTLE_CYC < 1) begin : g_bad_settle
        $error("SETTLE_CYC must be at least one");
    end

    localparam int QW = $clog2(QUEUE_DEPTH) + 1;

    logic [15:0] ctrl_ff;
    logic [15:0] irq_en_ff;
    logic [15:0] status_ff;
    logic [15:0] ack_ff;
    logic [15:0] dec_info_ff;
    logic [15:0] enc_info_ff;
    logic [15:0] speed_ff;
    logic [15:0] rdata_ff;
    logic [31:0] settle_ff;
    logic        settle_busy_ff;
    logic        fast_ff;
    logic        synth_ff;
    logic        irq_n_ff;
    logic        tx_valid_ff;
    logic [15:0] tx_data_ff;
    logic [QW-1:0] q_count;
    logic        q_tx_valid;
    logic [15:0] q_tx_data;
    logic        wanted_pulse;

    // Address decode
    wire wr_ctrl   = BUS_WR && (BUS_ADDR == ADDR_CONTROL_WORD);
    wire wr_cmd    = BUS_WR && (BUS_ADDR == ADDR_CODEC_CMD);
    wire wr_speed  = BUS_WR && (BUS_ADDR == ADDR_SPEED_SELECT);
    wire wr_wm     = BUS_WR && (BUS_ADDR == ADDR_WATERMARK);
    wire wr_irqen  = BUS_WR && (BUS_ADDR == ADDR_IRQ_ENABLE);
    wire wr_atten  = BUS_WR && (BUS_ADDR == ADDR_TONE_ATTEN);
    wire wr_ecc    = BUS_WR && (BUS_ADDR == ADDR_EXT_CODEC_CTRL);
    wire rd_status = BUS_RD && (BUS_ADDR == ADDR_STATUS);
    wire q_clear   = wr_ecc && (BUS_WDATA == CODEC_FIFO_CLEAR_CMD);

    // Reserved bits forced to zero so a stray host write cannot act on them
    wire [15:0] ctrl_clean = BUS_WDATA & 16'h3BFF;

    // Control field views
    wire dec_tone_detect_en   = ctrl_ff[CW_DEC_TONE_DETECT];
    wire dec_tone_generate_en = ctrl_ff[CW_DEC_TONE_GENERATE];
    wire dec_tone_first       = ctrl_ff[CW_DEC_TONE_FIRST];
    wire dec_keypad_detect_en = ctrl_ff[CW_DEC_KEYPAD_DETECT];
    wire enc_keypad_detect_en = ctrl_ff[CW_ENC_KEYPAD_DETECT];
    wire enc_tone_detect_en   = ctrl_ff[CW_ENC_TONE_DETECT];
    wire enc_tone_first       = ctrl_ff[CW_ENC_TONE_FIRST];

    // Decoder classification; order only matters when both detects on
    wire dec_tone_hit = DEC_FRAME_IS_TONE && dec_tone_detect_en;
    wire dec_key_hit  = DEC_FRAME_IS_KEYPAD && dec_keypad_detect_en;
    wire dec_take_tone = dec_tone_hit
        && !(dec_key_hit && !dec_tone_first);
    wire dec_take_key  = dec_key_hit && !dec_take_tone;

    // Encoder classification, same priority scheme
    wire enc_tone_hit = ENC_AUDIO_IS_TONE && enc_tone_detect_en;
    wire enc_key_hit  = ENC_AUDIO_IS_KEYPAD && enc_keypad_detect_en;
    wire enc_take_tone = enc_tone_hit
        && !(enc_key_hit && !enc_tone_first);
    wire enc_take_key  = enc_key_hit && !enc_take_tone;

    // Ready and service completion events
    wire ready_evt = wr_cmd || wr_wm || (settle_busy_ff && settle_ff == 32'd1);
    wire svc_evt   = wr_atten && (speed_ff == SPEED_SLOW || speed_ff == SPEED_FAST);

    // Register read mux; write-only locations read as zero
    wire [15:0] rd_mux =
        (BUS_ADDR == ADDR_STATUS)      ? status_ff :
        (BUS_ADDR == ADDR_QUEUE_COUNT) ? {{(16-QW){1'b0}}, q_count} :
        (BUS_ADDR == ADDR_SERVICE_ACK) ? ack_ff :
        (BUS_ADDR == ADDR_DEC_INFO)    ? dec_info_ff :
        (BUS_ADDR == ADDR_ENC_INFO)    ? enc_info_ff :
                                         16'h0000;

    // Sticky status events set over a read clear in the same cycle
    wire [15:0] status_set = {ready_evt, svc_evt, 5'b0_0000, wanted_pulse, 8'h00};
    wire [15:0] nxt_status = (rd_status ? 16'h0000 : status_ff) | status_set;

    // Codec command queue
    vtc_cmd_queue #(
        .DEPTH        (QUEUE_DEPTH)
    ) u_queue (
        .clk          (REF_CLK),
        .rst_n        (RESET_N),
        .push         (wr_cmd),
        .push_data    (BUS_WDATA),
        .clear        (q_clear),
        .replay_start (PORT_START),
        .tx_ready     (PORT_TX_READY),
        .tx_valid     (q_tx_valid),
        .tx_data      (q_tx_data),
        .count        (q_count)
    );

    // Watermark notifier
    vtc_watermark #(
        .CW           (WM_BITS)
    ) u_wm (
        .clk          (REF_CLK),
        .rst_n        (RESET_N),
        .wr           (wr_wm),
        .high_sel     (BUS_WDATA[WM_HIGH_SEL]),
        .level        (BUS_WDATA[WM_BITS-1:0]),
        .sample_count (SAMPLE_COUNT),
        .wanted_pulse (wanted_pulse)
    );

    // Control and enable registers
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ctrl_ff   <= CONTROL_RESET;
            irq_en_ff <= IRQ_ENABLE_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= ctrl_clean;
            end
            if (wr_irqen) begin
                irq_en_ff <= BUS_WDATA;
            end
        end
    end

    // Control change takes its settle time before ready is raised
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            settle_ff      <= 32'd0;
            settle_busy_ff <= 1'b0;
        end else if (wr_ctrl) begin
            settle_ff      <= 32'(SETTLE_CYC);
            settle_busy_ff <= 1'b1;
        end else if (settle_busy_ff) begin
            settle_ff      <= settle_ff - 32'd1;
            settle_busy_ff <= settle_ff != 32'd1;
        end
    end

    // Status, acknowledge and interrupt
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            status_ff <= 16'h0000;
            ack_ff    <= 16'h0000;
            irq_n_ff  <= 1'b1;
        end else begin
            status_ff <= nxt_status;
            if (wr_cmd) begin
                ack_ff <= 16'h0001;
            end else if (BUS_RD && BUS_ADDR == ADDR_SERVICE_ACK) begin
                ack_ff <= 16'h0000;
            end
            irq_n_ff  <= ~|(nxt_status & irq_en_ff);
        end
    end

    // Speed select is latched, then applied by the attenuation write
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            speed_ff <= 16'h0000;
            fast_ff  <= 1'b0;
        end else begin
            if (wr_speed) begin
                speed_ff <= BUS_WDATA;
            end
            if (svc_evt) begin
                fast_ff <= speed_ff == SPEED_FAST;
            end
        end
    end

    // Frame info registers: type in 15:14, data in 11:0
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            dec_info_ff <= 16'h0000;
            enc_info_ff <= 16'h0000;
            synth_ff    <= 1'b0;
        end else begin
            if (DEC_FRAME_VALID) begin
                dec_info_ff <= dec_take_tone ? {INFO_TONE, 2'b00, DEC_FRAME_DATA} :
                               dec_take_key  ? {INFO_KEYPAD, 2'b00, DEC_FRAME_DATA} :
                                               {INFO_VOICE, 14'h0000};
                synth_ff    <= dec_take_tone && dec_tone_generate_en;
            end
            if (ENC_AUDIO_VALID) begin
                enc_info_ff <= enc_take_tone ? {INFO_TONE, 2'b00, ENC_AUDIO_DATA} :
                               enc_take_key  ? {INFO_KEYPAD, 2'b00, ENC_AUDIO_DATA} :
                                               {INFO_VOICE, 14'h0000};
            end
        end
    end

    // Registered outputs
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            rdata_ff    <= 16'h0000;
            tx_valid_ff <= 1'b0;
            tx_data_ff  <= 16'h0000;
        end else begin
            rdata_ff    <= BUS_RD ? rd_mux : 16'h0000;
            tx_valid_ff <= q_tx_valid && PORT_TX_READY;
            tx_data_ff  <= q_tx_data;
        end
    end

    assign BUS_RDATA      = rdata_ff;
    assign PORT_TX_VALID  = tx_valid_ff;
    assign PORT_TX_DATA   = tx_data_ff;
    assign DEC_TONE_SYNTH = synth_ff;
    assign FAST_SPEED     = fast_ff;
    assign INTERRUPT_N    = irq_n_ff;
endmodule

/* File: src/vtc_pkg.sv */
package vtc_pkg;
    // Register addresses on the 8-bit serial control bus
    localparam logic [7:0]  ADDR_TONE_ATTEN     = 8'h0A;
    localparam logic [7:0]  ADDR_EXT_CODEC_CTRL = 8'h0B;
    localparam logic [7:0]  ADDR_CONTROL_WORD   = 8'h11;
    localparam logic [7:0]  ADDR_CODEC_CMD      = 8'h12;
    localparam logic [7:0]  ADDR_SPEED_SELECT   = 8'h1D;
    localparam logic [7:0]  ADDR_WATERMARK      = 8'h1E;
    localparam logic [7:0]  ADDR_IRQ_ENABLE     = 8'h1F;
    localparam logic [7:0]  ADDR_QUEUE_COUNT    = 8'h24;
    localparam logic [7:0]  ADDR_SERVICE_ACK    = 8'h2E;
    localparam logic [7:0]  ADDR_DEC_INFO       = 8'h37;
    localparam logic [7:0]  ADDR_ENC_INFO       = 8'h38;
    localparam logic [7:0]  ADDR_STATUS         = 8'h40;

    // Control word bit positions
    localparam int CW_DEC_KEYPAD_DETECT = 5;
    localparam int CW_DEC_TONE_DETECT   = 7;
    localparam int CW_DEC_TONE_GENERATE = 8;
    localparam int CW_DEC_TONE_FIRST    = 9;
    localparam int CW_ENC_KEYPAD_DETECT = 11;
    localparam int CW_ENC_TONE_DETECT   = 12;
    localparam int CW_ENC_TONE_FIRST    = 13;

    // Status bit positions
    localparam int ST_READY       = 15;
    localparam int ST_SERVICE     = 14;
    localparam int ST_FRAME_WANTED = 8;

    // Watermark field layout
    localparam int WM_HIGH_SEL = 15;
    localparam int WM_BITS     = 11;

    // Commands and codes
    localparam logic [15:0] CODEC_FIFO_CLEAR_CMD = 16'h0001;
    localparam logic [15:0] SPEED_SLOW           = 16'h0005;
    localparam logic [15:0] SPEED_FAST           = 16'h0006;
    localparam logic [15:0] IRQ_ENABLE_RESET     = 16'h8000;
    localparam logic [15:0] CONTROL_RESET        = 16'h0000;

    // Info register type field codes
    localparam logic [1:0]  INFO_VOICE  = 2'b00;
    localparam logic [1:0]  INFO_KEYPAD = 2'b01;
    localparam logic [1:0]  INFO_TONE   = 2'b10;

    // Timing: a control word change takes effect within 20 ms
    localparam int CLK_MHZ         = 100;
    localparam int CTRL_SETTLE_US  = 20000;
    localparam int CTRL_SETTLE_CYC = CTRL_SETTLE_US * CLK_MHZ;
    localparam int SPEED_SETTLE_CYC = 64;

    localparam int QUEUE_DEPTH   = 16;
    localparam int SAMPLE_BUF_MAX = 800;
endpackage

/* File: src/vtc_cmd_queue.sv */
`timescale 1ns/1ps
// Codec initialisation word store, replayed on each serial port start
module vtc_cmd_queue
    import vtc_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        push,
    input  wire logic [15:0] push_data,
    input  wire logic        clear,
    input  wire logic        replay_start,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic [15:0]      tx_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);

    // Refused at elaboration: the index wraps only on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two");
    end

    logic [15:0]   mem [DEPTH];
    logic [AW:0]   count_ff;
    logic [AW:0]   rd_ff;
    logic          run_ff;

    // Full store drops further words rather than wrapping
    wire           do_push = push && (count_ff != (AW+1)'(DEPTH));
    wire           do_send = run_ff && tx_ready;
    wire           last    = (rd_ff + 1'b1) == count_ff;

    // Words are kept after replay so a codec reset can reuse them
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[count_ff[AW-1:0]] <= push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            count_ff <= '0;
        end else if (do_push) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    // Replay walks the stored words once, then the port carries audio
    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            run_ff <= 1'b0;
            rd_ff  <= '0;
        end else if (replay_start) begin
            run_ff <= count_ff != '0;
            rd_ff  <= '0;
        end else if (do_send) begin
            rd_ff  <= rd_ff + 1'b1;
            run_ff <= !last;
        end
    end

    assign tx_valid = run_ff;
    assign tx_data  = mem[rd_ff[AW-1:0]];
    assign count    = count_ff;
endmodule

/* File: src/vtc_watermark.sv */
`timescale 1ns/1ps
// Data-wanted notifier with low/high hysteresis on the sample count
module vtc_watermark
    import vtc_pkg::*;
#(
    parameter int CW = WM_BITS
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          wr,
    input  wire logic          high_sel,
    input  wire logic [CW-1:0] level,
    input  wire logic [CW-1:0] sample_count,
    output logic               wanted_pulse
);
    // Refused at elaboration: a full buffer must fit the count width
    if (CW < 10) begin : g_bad_width
        $error("CW too narrow for the sample buffer");
    end

    logic [CW-1:0] low_ff;
    logic [CW-1:0] high_ff;
    logic          armed_ff;
    logic          pulse_ff;

    wire low_hit  = armed_ff && (sample_count < low_ff);
    wire high_hit = sample_count >= high_ff;

    // No reset values for the marks; disarmed until host programs them
    always_ff @(posedge clk) begin
        if (wr && !high_sel) begin
            low_ff <= level;
        end
        if (wr && high_sel) begin
            high_ff <= level;
        end
    end

    // Arm state: low write arms, high write waits for the high mark
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= 1'b0;
            if (wr) begin
                armed_ff <= !high_sel;
            end else if (low_hit) begin
                armed_ff <= 1'b0;
                pulse_ff <= 1'b1;
            end else if (!armed_ff && high_hit) begin
                armed_ff <= 1'b1;
            end
        end
    end

    assign wanted_pulse = pulse_ff;
endmodule

/* File: test/vtc_regs_sva.sv */
`timescale 1ns/1ps
// Port-level timing checks on the register block
module vtc_regs_chk
    import vtc_pkg::*;
(
    input wire logic        REF_CLK,
    input wire logic        RESET_N,
    input wire logic        BUS_WR,
    input wire logic        BUS_RD,
    input wire logic [7:0]  BUS_ADDR,
    input wire logic [15:0] BUS_WDATA,
    input wire logic [15:0] BUS_RDATA,
    input wire logic        DEC_FRAME_VALID,
    input wire logic        DEC_FRAME_IS_TONE,
    input wire logic        DEC_TONE_SYNTH,
    input wire logic        PORT_TX_READY,
    input wire logic        PORT_TX_VALID,
    input wire logic        INTERRUPT_N
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // Decoded write and read strobes
    wire wr_cmd = BUS_WR && BUS_ADDR == ADDR_CODEC_CMD;
    wire wr_wm  = BUS_WR && BUS_ADDR == ADDR_WATERMARK;
    wire wr_clr = BUS_WR && BUS_ADDR == ADDR_EXT_CODEC_CTRL && BUS_WDATA == CODEC_FIFO_CLEAR_CMD;
    wire rd_cnt = BUS_RD && BUS_ADDR == ADDR_QUEUE_COUNT;

    rdata_idle_a: assert property (!$past(BUS_RD) |-> BUS_RDATA == 16'h0000)
        else $error("read data not idle without a read");
    cmd_ready_a: assert property (wr_cmd |-> ##[1:3] !INTERRUPT_N)
        else $error("no interrupt after codec command write");
    wm_ready_a: assert property (wr_wm |-> ##[1:3] !INTERRUPT_N)
        else $error("no interrupt after watermark write");
    count_up_a: assert property (wr_cmd ##[1:8] rd_cnt |=> BUS_RDATA != 16'h0000)
        else $error("queue count zero after a push");
    clear_empty_a: assert property (wr_clr ##[1:3] rd_cnt |=> BUS_RDATA == 16'h0000)
        else $error("queue count not zero after clear");
    tx_paced_a: assert property (PORT_TX_VALID |-> $past(PORT_TX_READY))
        else $error("word sent while port not ready");
    synth_off_a: assert property (DEC_FRAME_VALID && !DEC_FRAME_IS_TONE |=> !DEC_TONE_SYNTH)
        else $error("tone synthesis after a non-tone frame");
    reset_idle_a: assert property ($rose(RESET_N) |-> INTERRUPT_N && !PORT_TX_VALID)
        else $error("outputs not idle after reset");
endmodule

/* File: test/vtc_host.sv */
`timescale 1ns/1ps
// Host on the register bus: one access at a time, one-cycle strobes
module vtc_host
    import vtc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [15:0] rdata,
    output logic             wr,
    output logic             rd,
    output logic [7:0]       addr,
    output logic [15:0]      wdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
    end
    // Released lines carry the inverse so stale values are never mistaken for live ones
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask
    // No other access until the bit shows; status clears on read, so all seen is kept
    task automatic wait_bit(input int b, output logic [15:0] acc, output bit ok);
        logic [15:0] v;
        acc = 16'h0000;
        ok = 1'b0;
        for (int n = 0; n < 100 && !ok; n++) begin
            rd_reg(ADDR_STATUS, v);
            acc = acc | v;
            ok = v[b];
        end
    endtask
endmodule

/* File: test/vtc_regs_bench.sv */
`timescale 1ns/1ps
// Bench: host model on the bus, frames and buffer level driven from here
module vtc_regs_bench
    import vtc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        bus_wr, bus_rd, dv = 1'b0, dt = 1'b0, dk = 1'b0, ev = 1'b0, et = 1'b0;
    logic        ek = 1'b0, start = 1'b0, txr = 1'b0, txv, synth, fast, irq_n;
    logic [7:0]  bus_addr;
    logic [15:0] bus_wdata, rdata, txd;
    logic [11:0] dd = 12'h000, ed = 12'h000;
    logic [10:0] cnt = 11'h258;
    logic [10:0] lvl [6] = '{11'h12C, 11'h12B, 11'h064, 11'h190, 11'h12B, 11'h190};
    logic        fire [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    integer      seed = 32'hd4947f04;
    int          err_total = 0;
    int          comparisons = 0;
    logic [15:0] q[$], got[$];

    always #5 clk = ~clk;
    vtc_regs #(.SETTLE_CYC(4)) i_vtc_regs (.REF_CLK(clk), .RESET_N(rst_n), .BUS_WR(bus_wr),
        .BUS_RD(bus_rd), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_RDATA(rdata),
        .DEC_FRAME_VALID(dv), .DEC_FRAME_IS_TONE(dt), .DEC_FRAME_IS_KEYPAD(dk),
        .DEC_FRAME_DATA(dd), .ENC_AUDIO_VALID(ev), .ENC_AUDIO_IS_TONE(et),
        .ENC_AUDIO_IS_KEYPAD(ek), .ENC_AUDIO_DATA(ed), .SAMPLE_COUNT(cnt), .PORT_START(start),
        .PORT_TX_READY(txr), .PORT_TX_VALID(txv), .PORT_TX_DATA(txd), .DEC_TONE_SYNTH(synth),
        .FAST_SPEED(fast), .INTERRUPT_N(irq_n));
    vtc_host i_vtc_host (.clk(clk), .rdata(rdata), .wr(bus_wr), .rd(bus_rd), .addr(bus_addr),
        .wdata(bus_wdata));
    // Words leaving on the codec port
    always @(posedge clk) if (txv) got.push_back(txd);

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_vtc_host.wr_reg(a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        i_vtc_host.rd_reg(a, d);
    endtask
    task automatic ready(input int b, output logic [15:0] acc);
        bit ok;
        i_vtc_host.wait_bit(b, acc, ok);
        if (!ok) begin
            err_total++;
            conclude();
        end
    endtask
    // Reference frame classifier: tone wins only when first or no keypad match
    function automatic logic [15:0] info(input logic [15:0] cw, input int kb, input int tb,
                                         input int fb, input logic t, input logic k,
                                         input logic [11:0] d);
        logic tone = t && cw[tb];
        logic key = k && cw[kb];
        if (tone && (!key || cw[fb])) return {INFO_TONE, 2'b00, d};
        if (key) return {INFO_KEYPAD, 2'b00, d};
        return {INFO_VOICE, 14'h0000};
    endfunction
    // Keypad codes use four data bits, voice none
    function automatic logic [15:0] msk(input logic [15:0] e);
        return e[15:14] == INFO_TONE ? 16'hCFFF : e[15:14] == INFO_KEYPAD ? 16'hC00F : 16'hC000;
    endfunction

    initial begin
        logic [15:0] v, e, cw;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk("irq_reset", {15'h0000, irq_n}, 16'h0001);
        // Speed has no default, so it is set first
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_SPEED_SELECT, s ? SPEED_SLOW : SPEED_FAST);
            wr(ADDR_TONE_ATTEN, 16'h0000);
            ready(ST_SERVICE, v);
            chk("fast_speed", {15'h0000, fast}, {15'h0000, s == 0});
        end
        rd(ADDR_QUEUE_COUNT, v);
        chk("count_reset", v, 16'h0000);
        for (int i = 0; i < QUEUE_DEPTH; i++) begin
            cw = 16'($random(seed));
            q.push_back(cw);
            wr(ADDR_CODEC_CMD, cw);
            ready(ST_READY, v);
            rd(ADDR_QUEUE_COUNT, v);
            chk("count", v, 16'(q.size()));
        end
        // A seventeenth word is dropped, so the count and the replay stay at sixteen
        wr(ADDR_CODEC_CMD, 16'hFFFF);
        ready(ST_READY, v);
        rd(ADDR_QUEUE_COUNT, v);
        chk("count_full", v, 16'(QUEUE_DEPTH));
        rd(ADDR_SERVICE_ACK, v);
        chk("ack", v & 16'h0001, 16'h0001);
        // Two replays with a stalling port: the queue must survive the first
        for (int r = 0; r < 2; r++) begin
            got.delete();
            @(posedge clk) start <= 1'b1;
            @(posedge clk) start <= 1'b0;
            for (int n = 0; n < 300 && got.size() < 16; n++) @(posedge clk) txr <= 1'($random(seed));
            repeat (8) @(posedge clk);
            chk("replay_len", 16'(got.size()), 16'h0010);
            foreach (q[i]) chk("replay_word", got[i], q[i]);
        end
        wr(ADDR_EXT_CODEC_CTRL, CODEC_FIFO_CLEAR_CMD);
        rd(ADDR_QUEUE_COUNT, v);
        chk("count_clear", v, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            cw = 16'($random(seed)) & 16'h3BA0; // Bits 10, 14 and 15 stay zero
            // Looped channel: the decoder mirrors every encoder detect
            cw[CW_DEC_TONE_DETECT]   |= cw[CW_ENC_TONE_DETECT];
            cw[CW_DEC_KEYPAD_DETECT] |= cw[CW_ENC_KEYPAD_DETECT];
            wr(ADDR_CONTROL_WORD, cw);
            ready(ST_READY, v);
            @(posedge clk) begin
                dv <= 1'b1;
                ev <= 1'b1;
                {dt, dk, et, ek, dd, ed} <= 28'($random(seed));
            end
            @(posedge clk) begin
                dv <= 1'b0;
                ev <= 1'b0;
            end
            e = info(cw, CW_DEC_KEYPAD_DETECT, CW_DEC_TONE_DETECT, CW_DEC_TONE_FIRST, dt, dk, dd);
            rd(ADDR_DEC_INFO, v);
            chk("dec_info", v & msk(e), e & msk(e));
            chk("synth", {15'h0000, synth}, {15'h0000, e[15:14] == INFO_TONE && cw[8]});
            e = info(cw, CW_ENC_KEYPAD_DETECT, CW_ENC_TONE_DETECT, CW_ENC_TONE_FIRST, et, ek, ed);
            rd(ADDR_ENC_INFO, v);
            chk("enc_info", v & msk(e), e & msk(e));
        end
        // Marks: high 400, low 300, buffer level stepped across both
        wr(ADDR_IRQ_ENABLE, 16'h8100);
        wr(ADDR_WATERMARK, 16'h8190);
        ready(ST_READY, v);
        wr(ADDR_WATERMARK, 16'h012C);
        ready(ST_READY, v);
        foreach (lvl[i]) begin
            @(posedge clk) cnt <= lvl[i];
            repeat (4) @(posedge clk);
            #1 chk("irq_level", {15'h0000, irq_n}, {15'h0000, !fire[i]});
            rd(ADDR_STATUS, v);
            chk("wanted", v & 16'h0100, {7'h00, fire[i], 8'h00});
        end
        wr(ADDR_WATERMARK, 16'h81F4);
        ready(ST_READY, v);
        @(posedge clk) cnt <= 11'h12B;
        repeat (4) @(posedge clk);
        rd(ADDR_STATUS, v);
        chk("disarmed", v & 16'h0100, 16'h0000);
        wr(ADDR_WATERMARK, 16'h012C);
        ready(ST_READY, cw);
        rd(ADDR_STATUS, v);
        chk("armed_now", (v | cw) & 16'h0100, 16'h0100);
        // Second reset with a word queued: the queue must come back empty
        wr(ADDR_CODEC_CMD, 16'h1234);
        ready(ST_READY, v);
        @(posedge clk) rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_QUEUE_COUNT, v);
        chk("count_rst", v, 16'h0000);
        conclude();
    end
endmodule

bind vtc_regs vtc_regs_chk i_vtc_regs_chk (.REF_CLK, .RESET_N, .BUS_WR, .BUS_RD, .BUS_ADDR,
    .BUS_WDATA, .BUS_RDATA, .DEC_FRAME_VALID, .DEC_FRAME_IS_TONE, .DEC_TONE_SYNTH,
    .PORT_TX_READY, .PORT_TX_VALID, .INTERRUPT_N);
